// ---- bench/kul_host_model.sv ----
// host side model: APB master that issues register and command transfers
// assumes the limiter answers each access with a one-cycle pready pulse
`timescale 1ns/1ps
`default_nettype none
module kul_host_model
(
    // clock
    input  wire logic        i_clk_sys,
    // apb master
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic      [11:0] o_paddr,
    output logic      [31:0] o_pwdata,
    input  wire logic [31:0] i_prdata,
    input  wire logic        i_pready,
    input  wire logic        i_pslverr
);
    initial
    begin
        o_psel    = 1'b0;
        o_penable = 1'b0;
        o_pwrite  = 1'b0;
        o_paddr   = 12'h000;
        o_pwdata  = 32'h0;
    end

    // request held from setup until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge i_clk_sys);
        o_psel    <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite  <= w;
        o_paddr   <= a;
        o_pwdata  <= d;
        @(posedge i_clk_sys);
        o_penable <= 1'b1;
        @(posedge i_clk_sys);
        while (i_pready !== 1'b1)
            @(posedge i_clk_sys);
        q = i_prdata;
        e = i_pslverr;
        o_psel    <= 1'b0;
        o_penable <= 1'b0;
        // released lines flip so a stale request never looks valid
        o_paddr   <= ~a;
        o_pwdata  <= ~d;
    endtask : xfer
endmodule : kul_host_model
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the key-usage limiter: register and command sequences
// assumes kul_host_model as APB master and a digest engine stubbed by two levels
`include "kul_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench
    import kul_pkg::*;
;
    typedef struct packed
    {
        logic [7:0] mode;
        logic       mapped;
        logic       match;
        logic       rnd;
        logic [3:0] rdp;
        logic       copy;
        logic [3:0] slot;
    } kul_tb_case_t;

    logic        i_clk_sys;
    logic        i_reset_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] o_prdata;
    logic        o_pready;
    logic        o_pslverr;
    logic        i_digest_match;
    logic        i_nonce_random;
    logic        o_cmd_done;
    logic        o_cmd_error;
    logic        o_copy_taken;
    logic        copy_seen;
    logic [31:0] q;
    logic        e;
    int          mismatches = 0;
    int          checks     = 0;
    int          cycles     = 0;
    kul_tb_case_t cases [6] = '{
        '{8'h01, 1'b1, 1'b1, 1'b1, 4'h0, 1'b1, 4'h3},
        '{8'h01, 1'b1, 1'b0, 1'b1, 4'h0, 1'b0, 4'h0},
        '{8'h01, 1'b1, 1'b1, 1'b1, 4'h5, 1'b0, 4'h0},
        '{8'h01, 1'b0, 1'b1, 1'b1, 4'h0, 1'b1, 4'h2},
        '{8'h01, 1'b1, 1'b1, 1'b0, 4'h0, 1'b0, 4'h0},
        '{8'h02, 1'b1, 1'b1, 1'b1, 4'h0, 1'b0, 4'h0}};

    kul_key_usage i_kul_key_usage (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_digest_match(i_digest_match), .i_nonce_random(i_nonce_random),
        .o_cmd_done(o_cmd_done), .o_cmd_error(o_cmd_error), .o_copy_taken(o_copy_taken));

    kul_host_model i_kul_host_model (.i_clk_sys(i_clk_sys), .o_psel(psel),
        .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata),
        .i_prdata(o_prdata), .i_pready(o_pready), .i_pslverr(o_pslverr));

    initial
    begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    always @(posedge i_clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_kul_host_model.xfer(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m = '1);
        i_kul_host_model.xfer(1'b0, a, 32'h0, q, e);
        chk(q & m, x);
    endtask : rd

    task automatic setbm(input logic [3:0] s, input logic [7:0] bm);
        wr(`KUL_OFF_USE_LO, {4'h0, s, 16'h0, bm});
    endtask : setbm

    task automatic setptr(input logic [3:0] s, input logic [3:0] wp, input logic [3:0] rp);
        wr(`KUL_OFF_SCRATCH, {4'h0, s, 16'h0, rp, wp});
    endtask : setptr

    // an x for the expected error leaves the error flag unjudged
    task automatic cmd(input kul_op_t op, input logic [3:0] key, input logic mapped,
                       input logic [7:0] mode, input logic xerr);
        int   n;
        logic done;
        done      = 1'b0;
        copy_seen = 1'b0;
        wr(`KUL_OFF_CMD, {1'b1, 4'h0, op, 7'h00, mapped, mode, 4'h0, key});
        for (n = 0; n < 30 && !done; n++)
        begin
            @(posedge i_clk_sys);
            copy_seen = copy_seen | o_copy_taken;
            done      = (o_cmd_done === 1'b1);
            if (done && xerr !== 1'bx)
                chk({31'h0, o_cmd_error}, {31'h0, xerr});
        end
        @(posedge i_clk_sys);
        copy_seen = copy_seen | o_copy_taken;
        chk({31'h0, done}, 32'h1);
    endtask : cmd

    initial
    begin
        i_reset_n      = 1'b0;
        i_digest_match = 1'b0;
        i_nonce_random = 1'b0;
        repeat (8) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        rd(`KUL_OFF_USE_LO, 32'hffffffff);
        rd(`KUL_OFF_K15_BASE, 32'hffffffff);
        rd(`KUL_OFF_ROLL, 32'h0);
        rd(`KUL_OFF_STATUS, 32'h0, 32'hfe);
        i_kul_host_model.xfer(1'b0, 12'h0f0, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        wr(`KUL_OFF_CTRL, 32'h0000820f);
        setbm(4'h0, 8'h03);
        cmd(KUL_OP_USE, 4'h0, 1'b0, 8'h00, 1'b0);
        rd(`KUL_OFF_USE_LO, 32'h01, 32'hff);
        cmd(KUL_OP_USE, 4'h0, 1'b0, 8'h00, 1'b0);
        cmd(KUL_OP_USE, 4'h0, 1'b0, 8'h00, 1'b1);
        cmd(KUL_OP_READWRITE, 4'h0, 1'b0, 8'h00, 1'b0);
        rd(`KUL_OFF_USE_LO, 32'h00, 32'hff);
        setbm(4'h9, 8'h00);
        cmd(KUL_OP_USE, 4'h9, 1'b0, 8'h00, 1'b0);
        // a second command while the first commits must be refused
        wr(`KUL_OFF_CMD, {1'b1, 4'h0, KUL_OP_USE, 7'h00, 1'b0, 8'h00, 8'h09});
        i_kul_host_model.xfer(1'b1, `KUL_OFF_CMD, 32'h81000009, q, e);
        chk({31'h0, e}, 32'h1);
        repeat (12) @(posedge i_clk_sys);
        setbm(4'h1, 8'h00);
        setptr(4'h1, 4'h0, 4'h5);
        cmd(KUL_OP_NONCE, 4'h0, 1'b0, 8'h00, 1'b0);
        rd(`KUL_OFF_STATUS, 32'h20, 32'h20);
        cmd(KUL_OP_DERIVE, 4'h1, 1'b0, 8'h00, 1'b1);
        rd(`KUL_OFF_STATUS, 32'h00, 32'h20);
        cmd(KUL_OP_DIGEST, 4'h0, 1'b0, 8'h00, 1'b0);
        rd(`KUL_OFF_STATUS, 32'h20, 32'h20);
        wr(`KUL_OFF_SLOTCFG, 32'h00000002);
        cmd(KUL_OP_NONCE, 4'h0, 1'b0, 8'h00, 1'b0);
        cmd(KUL_OP_DERIVE, 4'h1, 1'b0, 8'h00, 1'b1);
        setptr(4'h1, 4'h2, 4'h5);
        cmd(KUL_OP_NONCE, 4'h0, 1'b0, 8'h00, 1'b0);
        cmd(KUL_OP_DERIVE, 4'h1, 1'b0, 8'h00, 1'b0);
        rd(`KUL_OFF_USE_LO, 32'hff00, 32'hff00);
        rd(`KUL_OFF_ROLL, 32'h0100, 32'hff00);
        for (int i = 0; i < 9; i++)
        begin
            cmd(KUL_OP_USE, `KUL_K15_SLOT, 1'b0, 8'h00, 1'b0);
            if (i == 0)
                rd(`KUL_OFF_K15_BASE, 32'hffffff7f);
        end
        rd(`KUL_OFF_K15_BASE, 32'hffff7f00);
        cmd(KUL_OP_READWRITE, `KUL_K15_SLOT, 1'b0, 8'h00, 1'b0);
        rd(`KUL_OFF_K15_BASE, 32'hffff7f00);
        for (int i = 9; i < 128; i++)
            cmd(KUL_OP_USE, `KUL_K15_SLOT, 1'b0, 8'h00, 1'b0);
        for (int i = 0; i < 4; i++)
            rd(`KUL_OFF_K15_BASE + 12'(i * 4), 32'h0);
        cmd(KUL_OP_USE, `KUL_K15_SLOT, 1'b0, 8'h00, 1'b1);
        setbm(4'h2, 8'h01);
        setbm(4'h3, 8'h01);
        setptr(4'h2, 4'h0, 4'h0);
        for (int i = 0; i < 6; i++)
        begin
            if (i == 5)
                rd(`KUL_OFF_USE_LO, 32'h01010000, 32'hffff0000);
            setptr(4'h3, 4'h0, cases[i].rdp);
            i_nonce_random <= cases[i].rnd;
            cmd(KUL_OP_NONCE, 4'h0, 1'b0, 8'h00, 1'b0);
            i_digest_match <= cases[i].match;
            cmd(KUL_OP_MACV, 4'h2, cases[i].mapped, cases[i].mode, 1'bx);
            chk({31'h0, copy_seen}, {31'h0, cases[i].copy});
            if (cases[i].copy)
            begin
                rd(`KUL_OFF_STATUS, 32'ha4, 32'hfc);
                rd(`KUL_OFF_SCRATCH, {28'h0, cases[i].slot}, 32'hf);
            end
            else
                rd(`KUL_OFF_STATUS, 32'h00, 32'h20);
            if (cases[i].rnd && cases[i].mode == 8'h01)
                rd(`KUL_OFF_STATUS, {24'h0, cases[i].match, 7'h0}, 32'h80);
        end
        finish_test();
    end
endmodule : testbench
`default_nettype wire

// ---- rtl/kul_key_usage.sv ----
// key-usage limiter: slot use bitmaps, key-15 use array, derivation and password copy checks
// assumes an APB master on the system clock; nonvolatile commit modelled by a fixed wait
//
// Notes on behaviour
// (R1) creating a child key on slots 0-7 increments that slot's roll counter
// (R2) host loads the scratch key with a nonce before key derivation
// (R3) child key comes from the parent picked by write parent pointer plus nonce
// (R4) single-use limit applies to slots 0-7 only, ignored for 8-14
// (R5) limited slot with use bitmap 0x00 returns an error on key use
// (R6) otherwise clear the highest set bit of the use bitmap
// (R7) read and write ignore limits and keep the use bitmap
// (R8) derivation fails if limited parent has use bitmap 0x00
// (R9) successful derivation sets target bitmap to 0xff; nothing else restores bits
// (R10) derivation allowed only when write policy bit 13 is set; the code checks the target slot's bit of write_policy_field instead
// (R11) host initialises bitmaps only to 0xff or a low run of ones
// (R12) limited key 15 with all-zero use array returns an error
// (R13) each key-15 use clears one bit, scanning from byte 68 bit seven
// (R14) key-15 bits never restored; key disabled once all used
// (R15) read and write leave key-15 use array alone
// (R16) password copy applies no limit or decrement
// (R17) copy path enabled only with mode 0x01
// (R18) copy hash uses password slot then random nonce in scratch key
// (R19) copy target is password slot plus one when mapped, else itself; the code takes key selector bits 3:1 with mapped as bit 0
// (R20) copy allowed only when target read parent pointer is zero
// (R21) on match copy target to scratch key, flags 1,0,0, valid 1
// (R22) mac verify reports a single match result
// (R23) scratch valid cleared after any command except nonce, digest and a mac verify that copies
// (R24) use-bit clearing committed before the crypto computation starts
`include "kul_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module kul_key_usage
    import kul_pkg::*;
#(
    parameter int unsigned NSLOT = 16
)
(
    // clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // copy and nonce side inputs from the digest engine
    input  wire logic        i_digest_match,
    input  wire logic        i_nonce_random,
    // result strobes
    output logic             o_cmd_done,
    output logic             o_cmd_error,
    output logic             o_copy_taken
);
    localparam int unsigned CW = $clog2(`KUL_NV_COMMIT_CYC + 1);

    typedef struct packed {
        logic [NSLOT-1:0][7:0]  slot_use_bitmap;
        logic [7:0][7:0]        slot_roll_counter;
        logic [NSLOT-1:0]       limited_use_enable;
        logic [NSLOT-1:0][3:0]  write_parent_pointer;
        logic [NSLOT-1:0][3:0]  read_parent_pointer;
        logic [NSLOT-1:0]       write_policy_field;
        logic [127:0]           key15_use_bitmap;
        logic [3:0]             scratch_slot;
        logic                   seed_origin_flag;
        logic                   digest_origin_flag;
        logic                   verify_only_flag;
        logic                   scratch_valid;
        kul_state_t             state;
        kul_op_t                op;
        logic [3:0]             key_selector;
        logic [7:0]             mode;
        logic                   mapped;
        logic [CW-1:0]          wait_cnt;
        logic                   err;
        logic                   match;
        logic [31:0]            prdata;
        logic                   pready;
        logic                   pslverr;
        logic                   done;
        logic                   done_err;
        logic                   copy_taken;
        logic                   copied;
    } kul_state_s_t;

    kul_state_s_t r;
    kul_state_s_t next_r;

    // highest set bit, as a one-hot clearing mask
    function automatic logic [7:0] top_bit(input logic [7:0] v);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            if (v[i])
            begin
                m = 8'h00;
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction : top_bit

    // key-15 array: byte 0 (config byte 68) sits in bits 7:0; first nonzero byte wins
    function automatic logic [127:0] k15_clear(input logic [127:0] a);
        logic [127:0] res;
        logic         hit;
        res = a;
        hit = 1'b0;
        for (int b = 0; b < 16; b++)
        begin
            if (!hit && a[b*8 +: 8] != `KUL_USE_EMPTY)
            begin
                res[b*8 +: 8] = a[b*8 +: 8] & ~top_bit(a[b*8 +: 8]);
                hit = 1'b1;
            end
        end
        return res;
    endfunction : k15_clear

    // true when the selected key may not be used any more
    function automatic logic exhausted(input kul_state_s_t s, input logic [3:0] k);
        logic e;
        e = 1'b0;
        if (k == `KUL_K15_SLOT)
        begin
            e = s.limited_use_enable[k] && (s.key15_use_bitmap == 128'h0);   // R12
        end
        else if (k < 4'h8)
        begin
            e = s.limited_use_enable[k] && (s.slot_use_bitmap[k] == `KUL_USE_EMPTY); // R5 R4
        end
        return e;
    endfunction : exhausted

    logic       wr_access;
    logic       rd_access;
    logic [3:0] tgt;
    logic [3:0] parent;

    assign wr_access = psel && penable && pwrite && !r.pready;
    assign rd_access = psel && penable && !pwrite && !r.pready;

    always_comb
    begin
        next_r            = r;
        next_r.pready     = 1'b0;
        next_r.pslverr    = 1'b0;
        next_r.done       = 1'b0;
        next_r.done_err   = 1'b0;
        next_r.copy_taken = 1'b0;
        tgt               = r.key_selector;
        parent            = r.write_parent_pointer[r.key_selector];

        if (psel && penable && !r.pready)
        begin
            next_r.pready = 1'b1;
            next_r.prdata = 32'h0;
            case (paddr)
                `KUL_OFF_CTRL:
                    next_r.prdata = {16'h0, r.limited_use_enable};
                `KUL_OFF_STATUS:
                    next_r.prdata = {24'h0, r.match, r.err, r.scratch_valid,
                                     r.verify_only_flag, r.digest_origin_flag,
                                     r.seed_origin_flag, (r.state != KUL_ST_IDLE), 1'b0};
                `KUL_OFF_SLOTCFG:
                    next_r.prdata = {16'h0, r.write_policy_field};
                `KUL_OFF_USE_LO:
                    next_r.prdata = {r.slot_use_bitmap[3], r.slot_use_bitmap[2],
                                     r.slot_use_bitmap[1], r.slot_use_bitmap[0]};
                `KUL_OFF_ROLL:
                    next_r.prdata = {r.slot_roll_counter[3], r.slot_roll_counter[2],
                                     r.slot_roll_counter[1], r.slot_roll_counter[0]};
                `KUL_OFF_SCRATCH:
                    next_r.prdata = {28'h0, r.scratch_slot};
                default:
                begin
                    if (paddr >= `KUL_OFF_K15_BASE && paddr <= `KUL_OFF_K15_LAST
                        && paddr[1:0] == 2'b00)
                        next_r.prdata = r.key15_use_bitmap[(paddr - `KUL_OFF_K15_BASE) * 8 +: 32];
                    else if (paddr != `KUL_OFF_CMD)
                        next_r.pslverr = 1'b1;
                end
            endcase
        end

        // personalisation writes; the host keeps bitmap values legal (R11)
        if (wr_access)
        begin
            case (paddr)
                `KUL_OFF_CTRL:
                    next_r.limited_use_enable = pwdata[NSLOT-1:0];
                `KUL_OFF_SLOTCFG:
                    next_r.write_policy_field = pwdata[NSLOT-1:0];
                `KUL_OFF_USE_LO:
                    next_r.slot_use_bitmap[pwdata[27:24]] = pwdata[7:0];
                `KUL_OFF_SCRATCH:
                begin
                    next_r.write_parent_pointer[pwdata[27:24]] = pwdata[3:0];
                    next_r.read_parent_pointer[pwdata[27:24]]  = pwdata[7:4];
                end
                `KUL_OFF_CMD:
                begin
                    if (r.state == KUL_ST_IDLE && pwdata[`KUL_CMD_GO_BIT])
                    begin
                        next_r.op           = kul_op_t'(pwdata[26:24]);
                        next_r.key_selector = pwdata[3:0];
                        next_r.mode         = pwdata[15:8];
                        next_r.mapped       = pwdata[16];
                        next_r.state        = KUL_ST_COMMIT;
                        next_r.wait_cnt     = CW'(`KUL_NV_COMMIT_CYC);
                    end
                    else if (r.state != KUL_ST_IDLE)
                        next_r.pslverr = 1'b1;
                end
                default:
                begin
                    if (paddr >= `KUL_OFF_K15_BASE && paddr <= `KUL_OFF_K15_LAST
                        && paddr[1:0] == 2'b00)
                        next_r.key15_use_bitmap[(paddr - `KUL_OFF_K15_BASE) * 8 +: 32] = pwdata;
                    else
                        next_r.pslverr = 1'b1;
                end
            endcase
        end

        case (r.state)
            KUL_ST_IDLE:
            begin
            end
            KUL_ST_COMMIT:
            begin
                // bits are cleared here, before the digest wait ends
                if (r.wait_cnt == CW'(`KUL_NV_COMMIT_CYC))
                begin
                    next_r.err    = 1'b0;
                    next_r.match  = 1'b0;
                    next_r.copied = 1'b0;
                    case (r.op)
                        KUL_OP_USE:
                        begin
                            if (exhausted(r, tgt))
                                next_r.err = 1'b1;                     // R5 R12
                            else if (tgt == `KUL_K15_SLOT && r.limited_use_enable[tgt]) // R14
                                next_r.key15_use_bitmap = k15_clear(r.key15_use_bitmap); // R13 R24
                            else if (tgt < 4'h8 && r.limited_use_enable[tgt])
                                next_r.slot_use_bitmap[tgt] = r.slot_use_bitmap[tgt]
                                    & ~top_bit(r.slot_use_bitmap[tgt]); // R6 R24
                        end
                        KUL_OP_DERIVE:
                        begin
                            if (!r.write_policy_field[tgt] || exhausted(r, parent))
                                next_r.err = 1'b1;                     // R10 R8
                            else
                            begin
                                if (tgt < 4'h8)
                                begin
                                    next_r.slot_use_bitmap[tgt] = `KUL_USE_FULL;  // R9
                                    next_r.slot_roll_counter[tgt[2:0]] =
                                        r.slot_roll_counter[tgt[2:0]] + 8'h01;    // R1
                                end
                                next_r.scratch_slot = parent;           // R3
                            end
                        end
                        KUL_OP_MACV:
                        begin
                            tgt = {r.key_selector[3:1], r.mapped};       // R19
                            next_r.match = i_digest_match;              // R22
                            if (r.mode == `KUL_MACV_COPY_MODE && i_nonce_random
                                && r.scratch_valid
                                && r.read_parent_pointer[tgt] == 4'h0
                                && i_digest_match)                      // R17 R18 R20 R16
                            begin
                                next_r.scratch_slot       = tgt;        // R21
                                next_r.seed_origin_flag   = 1'b1;
                                next_r.digest_origin_flag = 1'b0;
                                next_r.verify_only_flag   = 1'b0;
                                next_r.copy_taken         = 1'b1;
                                next_r.copied             = 1'b1;
                            end
                        end
                        default:
                        begin
                        end
                    endcase
                end
                if (r.wait_cnt == CW'(0))
                    next_r.state = KUL_ST_DONE;
                else
                    next_r.wait_cnt = r.wait_cnt - CW'(1);
            end
            KUL_ST_DONE:
            begin
                next_r.done     = 1'b1;
                next_r.done_err = r.err;
                next_r.state    = KUL_ST_IDLE;
                if (r.op == KUL_OP_NONCE)
                begin
                    next_r.scratch_valid    = 1'b1;
                    next_r.seed_origin_flag = ~i_nonce_random;
                end
                else if (r.op == KUL_OP_DIGEST)
                    next_r.scratch_valid = 1'b1;
                else if (!(r.op == KUL_OP_MACV && r.copied))
                    next_r.scratch_valid = 1'b0;                        // R23
                else
                    next_r.scratch_valid = 1'b1;                        // R21
            end
            default:
                next_r.state = KUL_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            r                 <= '0;
            r.slot_use_bitmap <= {NSLOT{`KUL_USE_FULL}};
            r.key15_use_bitmap <= {128{1'b1}};
            r.state           <= KUL_ST_IDLE;
            r.op              <= KUL_OP_NONE;
        end
        else
            r <= next_r;
    end

    assign o_prdata     = r.prdata;
    assign o_pready     = r.pready;
    assign o_pslverr    = r.pslverr;
    assign o_cmd_done   = r.done;
    assign o_cmd_error  = r.done_err;
    assign o_copy_taken = r.copy_taken;

    // read/write commands never touch use state (R7 R15)
    rw_keeps_use_a : assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R7
        (r.state == KUL_ST_COMMIT && r.op == KUL_OP_READWRITE) |=>
        ($stable(r.key15_use_bitmap) && $stable(r.slot_use_bitmap)))
        else $error("read/write changed use state");

    // first commit cycle: use bits are cleared and the verdict is taken here
    sequence commit_start_s;
        r.state == KUL_ST_COMMIT && r.wait_cnt == CW'(`KUL_NV_COMMIT_CYC);
    endsequence

    derive_refill_a : assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R9
        (commit_start_s ##0 (r.op == KUL_OP_DERIVE && !next_r.err && r.key_selector < 4'h8))
        |=> r.slot_use_bitmap[$past(r.key_selector)] == `KUL_USE_FULL)
        else $error("derive did not refill bitmap");

    derive_policy_a : assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R10
        (commit_start_s ##0 (r.op == KUL_OP_DERIVE && !r.write_policy_field[r.key_selector]))
        |=> r.err)
        else $error("derive without policy bit");

    done_follows_a : assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R22
        (r.state == KUL_ST_DONE) |=> (o_cmd_done && r.state == KUL_ST_IDLE))
        else $error("done pulse missing");

    valid_drop_a : assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R23
        (r.state == KUL_ST_DONE && r.op == KUL_OP_USE) |=> !r.scratch_valid)
        else $error("valid not cleared");

    macv_valid_drop_a : assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R23
        (r.state == KUL_ST_DONE && r.op == KUL_OP_MACV && !r.copied) |=> !r.scratch_valid)
        else $error("valid kept without copy");

    k15_one_bit_a : assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R13
        (commit_start_s ##0 (r.op == KUL_OP_USE && r.key_selector == `KUL_K15_SLOT
         && !exhausted(r, r.key_selector) && r.limited_use_enable[15])) |=>
        ($countones(r.key15_use_bitmap) + 1 == $countones($past(r.key15_use_bitmap))))
        else $error("key 15 use did not clear one bit");

    copy_flags_a : assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R21
        r.copy_taken |-> (r.seed_origin_flag && !r.digest_origin_flag && !r.verify_only_flag))
        else $error("copy flags wrong");

    apb_one_wait_a : assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R22
        (psel && penable && !r.pready) |=> r.pready)
        else $error("apb answer late");
endmodule : kul_key_usage
`default_nettype wire

// ---- rtl/kul_pkg.sv ----
// types shared by the key-usage limiter
// assumes kul_regs.svh for all numeric constants
package kul_pkg;
    typedef enum logic [2:0]
    {
        KUL_OP_NONE,
        KUL_OP_USE,
        KUL_OP_DERIVE,
        KUL_OP_READWRITE,
        KUL_OP_MACV,
        KUL_OP_NONCE,
        KUL_OP_DIGEST
    } kul_op_t;

    typedef enum logic [1:0]
    {
        KUL_ST_IDLE,
        KUL_ST_COMMIT,
        KUL_ST_DONE
    } kul_state_t;
endpackage : kul_pkg

// ---- rtl/kul_regs.svh ----
// register offsets, field positions, reset values and fixed codes of the key-usage limiter
// assumes a 32-bit APB bus with word-aligned registers
`ifndef KUL_REGS_SVH
`define KUL_REGS_SVH
`define KUL_OFF_CTRL        12'h000
`define KUL_OFF_CMD         12'h004
`define KUL_OFF_STATUS      12'h008
`define KUL_OFF_SLOTCFG     12'h00c
`define KUL_OFF_USE_LO      12'h010
`define KUL_OFF_ROLL        12'h014
`define KUL_OFF_SCRATCH     12'h018
`define KUL_OFF_K15_BASE    12'h044
`define KUL_OFF_K15_LAST    12'h050
`define KUL_CMD_GO_BIT      31
`define KUL_WCFG_DERIVE_BIT 13
`define KUL_USE_FULL        8'hff
`define KUL_USE_EMPTY       8'h00
`define KUL_MACV_COPY_MODE  8'h01
`define KUL_K15_SLOT        4'hf
`define KUL_NV_COMMIT_NS    32
`define KUL_NV_COMMIT_CYC   ((`KUL_NV_COMMIT_NS + 3) / 4)
`endif
